// File: rtl/interval_timer_pkg.sv
/*
 * Shared constants for the 16-bit interval timer: register offsets,
 * control field positions, status layout, reset values and prescaler limits.
 * Assumes a byte-addressed register port with one register per 32-bit word.
 */
package interval_timer_pkg;
    // register offsets (byte addresses)
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_COUNT = 5'h04;
    localparam logic [4:0] ADDR_PERIOD = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_CLEAR = 5'h10;
    localparam logic [4:0] ADDR_ENABLE = 5'h14;
    localparam logic [4:0] ADDR_PRIO = 5'h18;

    // control register field positions
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_IDLE_STOP_BIT = 13;
    localparam int CTRL_GATE_BIT = 6;
    localparam int CTRL_PRESC_HI = 5;
    localparam int CTRL_PRESC_LO = 4;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_SOSC_BIT = 0;

    // status, clear and enable share this layout
    localparam int STAT_MATCH_BIT = 0;
    localparam int STAT_GATE_BIT = 1;
    localparam int NUM_EVENTS = 2;
    localparam int PRIO_W = 3;

    // values after reset
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [2:0] PRIO_RESET = 3'h4;

    // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PRESC_LIM_1 = 8'h00;
    localparam logic [7:0] PRESC_LIM_8 = 8'h07;
    localparam logic [7:0] PRESC_LIM_64 = 8'h3f;
    localparam logic [7:0] PRESC_LIM_256 = 8'hff;
endpackage

// File: rtl/interval_timer.sv
/*
 * 16-bit interval timer / counter with prescaler, gate, period match
 * and a level interrupt, reached over a simple address/strobe port.
 * Assumes one 125 MHz clock that is also the instruction-cycle clock,
 * and pin inputs that may be asynchronous to it.
 */
// Decided for this implementation: the register addresses and the strobed register port.
// Functional notes
// - one 16-bit up-counter, timer or counter
// - timer, synchronous and asynchronous counter modes
// - period match zeroes count, sets flag
// - equality comparator drives reset and flag
// - gated mode: gate falling edge sets flag
// - prescaler divides by 1, 8, 64, 256
// - keeps counting in idle unless idle stop is set; in sleep only as asynchronous counter
// - select internal or external clock, gating
// - sync select: synchronised or asynchronous external
`timescale 1ns/10ps
module interval_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // power modes
    input wire logic i_idle,
    input wire logic i_sleep,
    // external clock and oscillator
    input wire logic i_external_count_clock_pin,
    input wire logic i_secondary_osc_in,
    output logic o_secondary_osc_out,
    // interrupt
    output logic o_irq,
    output logic [2:0] o_counter_irq_priority
);
    typedef struct packed {
        logic on;
        logic idle_stop;
        logic gate_en;
        logic [1:0] presc;
        logic sync_sel;
        logic src_sel;
        logic sosc_en;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] period;
        logic [1:0] status;
        logic [1:0] enable;
        logic [2:0] prio;
        logic [7:0] presc_cnt;
        logic ext_s1;
        logic ext_s2;
        logic ext_s_prev;
        logic ext_a;
        logic ext_a_prev;
        logic osc_out;
        logic [15:0] rdata;
        logic irq;
    } state_t;

    state_t q;
    state_t next_q;

    logic ext_raw;
    logic sync_edge;
    logic async_edge;
    logic running;
    logic src_pulse;
    logic tick;
    logic match;
    logic gate_fall;
    logic [7:0] presc_lim;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic [15:0] rd_val;

    // next-state logic for the whole block
    always_comb begin
        next_q = q;
        // oscillator input replaces the pin when enabled
        ext_raw = q.sosc_en ? i_secondary_osc_in : i_external_count_clock_pin;
        next_q.osc_out = q.sosc_en & ~i_secondary_osc_in;
        // two-stage synchroniser; ext_s1 feeds only ext_s2
        next_q.ext_s1 = ext_raw;
        next_q.ext_s2 = q.ext_s1;
        next_q.ext_s_prev = q.ext_s2;
        // single capture flop: faster but unprotected against metastability
        next_q.ext_a = ext_raw;
        next_q.ext_a_prev = q.ext_a;
        sync_edge = q.ext_s2 & ~q.ext_s_prev;
        async_edge = q.ext_a & ~q.ext_a_prev;

        // count source and mode selection
        running = q.on && !(i_idle && q.idle_stop);
        src_pulse = 1'b0;
        if (!q.src_sel) begin
            // internal clock; gate level pauses it in gated mode
            src_pulse = running && !i_sleep && (!q.gate_en || q.ext_s2);
        end else if (q.sync_sel) begin
            // synchronous counter stops with the system clock in sleep
            src_pulse = running && !i_sleep && sync_edge;
        end else begin
            // asynchronous counter keeps running in sleep
            src_pulse = running && async_edge;
        end

        // prescaler
        case (q.presc)
            2'h0: presc_lim = interval_timer_pkg::PRESC_LIM_1;
            2'h1: presc_lim = interval_timer_pkg::PRESC_LIM_8;
            2'h2: presc_lim = interval_timer_pkg::PRESC_LIM_64;
            default: presc_lim = interval_timer_pkg::PRESC_LIM_256;
        endcase
        // >= so a ratio lowered while running cannot wrap through 256
        tick = src_pulse && (q.presc_cnt >= presc_lim);
        if (!q.on || tick) begin
            next_q.presc_cnt = '0;
        end else if (src_pulse) begin
            next_q.presc_cnt = q.presc_cnt + 8'h01;
        end

        // period comparator and counter
        match = (q.count == q.period);
        if (i_wr && i_addr == interval_timer_pkg::ADDR_COUNT) begin
            // software load beats a coinciding increment
            next_q.count = i_wdata[CNT_W-1:0];
        end else if (tick) begin
            next_q.count = match ? '0 : q.count + 1'b1;
        end

        // gate falling edge, only in gated internal mode
        gate_fall = q.on && q.gate_en && !q.src_sel && q.ext_s_prev && !q.ext_s2;

        // sticky events; a set in the clear cycle wins
        ev_set = '0;
        ev_set[interval_timer_pkg::STAT_MATCH_BIT] = tick && match;
        ev_set[interval_timer_pkg::STAT_GATE_BIT] = gate_fall;
        ev_clr = (i_wr && i_addr == interval_timer_pkg::ADDR_CLEAR) ? i_wdata[1:0] : 2'h0;
        next_q.status = (q.status & ~ev_clr) | ev_set;

        // register writes
        if (i_wr) begin
            case (i_addr)
                interval_timer_pkg::ADDR_CTRL: begin
                    next_q.on = i_wdata[interval_timer_pkg::CTRL_ON_BIT];
                    next_q.idle_stop = i_wdata[interval_timer_pkg::CTRL_IDLE_STOP_BIT];
                    next_q.gate_en = i_wdata[interval_timer_pkg::CTRL_GATE_BIT];
                    next_q.presc = i_wdata[interval_timer_pkg::CTRL_PRESC_HI:interval_timer_pkg::CTRL_PRESC_LO];
                    next_q.sync_sel = i_wdata[interval_timer_pkg::CTRL_SYNC_BIT];
                    next_q.src_sel = i_wdata[interval_timer_pkg::CTRL_SRC_BIT];
                    next_q.sosc_en = i_wdata[interval_timer_pkg::CTRL_SOSC_BIT];
                end
                interval_timer_pkg::ADDR_PERIOD: begin
                    next_q.period = i_wdata[CNT_W-1:0];
                end
                interval_timer_pkg::ADDR_ENABLE: begin
                    next_q.enable = i_wdata[1:0];
                end
                interval_timer_pkg::ADDR_PRIO: begin
                    next_q.prio = i_wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // read mux; unmapped and write-only offsets read zero
        rd_val = '0;
        case (i_addr)
            interval_timer_pkg::ADDR_CTRL: begin
                rd_val[interval_timer_pkg::CTRL_ON_BIT] = q.on;
                rd_val[interval_timer_pkg::CTRL_IDLE_STOP_BIT] = q.idle_stop;
                rd_val[interval_timer_pkg::CTRL_GATE_BIT] = q.gate_en;
                rd_val[interval_timer_pkg::CTRL_PRESC_HI:interval_timer_pkg::CTRL_PRESC_LO] = q.presc;
                rd_val[interval_timer_pkg::CTRL_SYNC_BIT] = q.sync_sel;
                rd_val[interval_timer_pkg::CTRL_SRC_BIT] = q.src_sel;
                rd_val[interval_timer_pkg::CTRL_SOSC_BIT] = q.sosc_en;
            end
            interval_timer_pkg::ADDR_COUNT: rd_val[CNT_W-1:0] = q.count;
            interval_timer_pkg::ADDR_PERIOD: rd_val[CNT_W-1:0] = q.period;
            interval_timer_pkg::ADDR_STATUS: rd_val[1:0] = q.status;
            interval_timer_pkg::ADDR_ENABLE: rd_val[1:0] = q.enable;
            interval_timer_pkg::ADDR_PRIO: rd_val[2:0] = q.prio;
            default: rd_val = '0;
        endcase
        // data stand only in the cycle after the strobe
        next_q.rdata = i_rd ? rd_val : 16'h0000;

        // level interrupt from enabled sticky bits
        next_q.irq = |(next_q.status & next_q.enable);
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.count <= interval_timer_pkg::COUNT_RESET;
            q.period <= interval_timer_pkg::PERIOD_RESET;
            q.prio <= interval_timer_pkg::PRIO_RESET;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops
    assign o_rdata = q.rdata;
    assign o_irq = q.irq;
    assign o_counter_irq_priority = q.prio;
    assign o_secondary_osc_out = q.osc_out;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_count_holds_off: assert property (
        (!q.on && !(i_wr && i_addr == interval_timer_pkg::ADDR_COUNT)) |=> (q.count == $past(q.count))
    ) else $error("count moved while timer off");

    a_count_steps_up: assert property (
        (tick && !match && !(i_wr && i_addr == interval_timer_pkg::ADDR_COUNT)) |=> (q.count == $past(q.count) + 1'b1)
    ) else $error("count did not advance by one");

    a_match_wraps_flag: assert property (
        (tick && q.count == q.period && !(i_wr && i_addr == interval_timer_pkg::ADDR_COUNT))
            |=> (q.count == '0) && q.status[interval_timer_pkg::STAT_MATCH_BIT]
    ) else $error("period match did not wrap and flag");

    a_flag_needs_match: assert property (
        $rose(q.status[interval_timer_pkg::STAT_MATCH_BIT]) |-> ($past(tick) && $past(q.count) == $past(q.period))
    ) else $error("match flag without equality");

    a_gate_fall_flag: assert property (
        gate_fall |=> q.status[interval_timer_pkg::STAT_GATE_BIT] ##1 (o_irq == q.enable[interval_timer_pkg::STAT_GATE_BIT]
            || q.status[interval_timer_pkg::STAT_MATCH_BIT] || !q.status[interval_timer_pkg::STAT_GATE_BIT])
    ) else $error("gate falling edge not flagged");

    a_prescale_divide: assert property (
        (q.on && q.presc == 2'h1 && q.presc_cnt == 8'h00 && src_pulse) |-> !tick
    ) else $error("prescaler 1:8 ticked early");

    a_sleep_async_only: assert property (
        (i_sleep && !(q.src_sel && !q.sync_sel)) |-> !src_pulse
    ) else $error("clocked mode counted during sleep");

    a_gate_blocks_count: assert property (
        (!q.src_sel && q.gate_en && !q.ext_s2) |-> !src_pulse
    ) else $error("gated timer counted with gate low");

    a_sync_edge_delay: assert property (
        (q.on && q.src_sel && q.sync_sel && !i_sleep && !(i_idle && q.idle_stop) && q.ext_s2 && !q.ext_s_prev)
            |-> src_pulse
    ) else $error("synchronised edge not counted");

    a_irq_level: assert property (
        o_irq == |(q.status & q.enable)
    ) else $error("interrupt level disagrees with status");

    a_prescale_unity: assert property (
        (q.presc == 2'h0) |-> (tick == src_pulse)
    ) else $error("1:1 prescale dropped a pulse");

    a_prescale_last: assert property (
        (q.presc == 2'h3 && q.presc_cnt != 8'hff) |-> !tick
    ) else $error("prescaler 1:256 ticked early");

    a_count_load: assert property (
        (i_wr && i_addr == interval_timer_pkg::ADDR_COUNT) |=> (q.count == $past(i_wdata[CNT_W-1:0]))
    ) else $error("count load lost");

    a_match_set_wins: assert property (
        (tick && match) |=> q.status[interval_timer_pkg::STAT_MATCH_BIT]
    ) else $error("match flag lost to clear");

    a_gate_flag_clears: assert property (
        (i_wr && i_addr == interval_timer_pkg::ADDR_CLEAR && i_wdata[interval_timer_pkg::STAT_GATE_BIT]
            && !gate_fall) |=> !q.status[interval_timer_pkg::STAT_GATE_BIT]
    ) else $error("gate flag not cleared");

    a_async_in_sleep: assert property (
        (q.on && q.src_sel && !q.sync_sel && !(i_idle && q.idle_stop) && async_edge) |-> src_pulse
    ) else $error("asynchronous counter missed an edge");

    a_async_no_sync: assert property (
        (q.src_sel && !q.sync_sel && !async_edge) |-> !src_pulse
    ) else $error("asynchronous mode counted without an edge");

    a_idle_stop_halts: assert property (
        (i_idle && q.idle_stop) |-> !src_pulse
    ) else $error("counted in idle with idle stop set");

    a_gate_high_counts: assert property (
        (q.on && !q.src_sel && q.gate_en && q.ext_s2 && !i_sleep && !(i_idle && q.idle_stop)) |-> src_pulse
    ) else $error("gated timer missed a cycle with gate high");

    a_osc_routed: assert property (
        q.sosc_en |=> (q.ext_s1 == $past(i_secondary_osc_in))
    ) else $error("oscillator not routed to count input");

    a_osc_out_idle: assert property (
        !$past(q.sosc_en) |-> !o_secondary_osc_out
    ) else $error("oscillator output driven while disabled");
endmodule

// File: dv/ext_clock_model.sv
/*
 * behavioural external clock source that drives the count clock pin
 * assumes the bench pulses i_start for one cycle and holds i_pulses and i_half
 */
`timescale 1ns/10ps
module ext_clock_model (
    // clock and burst request
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [7:0] i_pulses,
    input wire logic [7:0] i_half,
    // pin side
    output logic o_pin,
    output logic o_busy
);
    int n;
    // the pin rests low between bursts, like an idle clock line
    initial begin
        o_pin = 1'b0;
        o_busy = 1'b0;
    end
    // square burst, changed just after each edge; slow pulses via a wide i_half
    always @(posedge i_clk) begin
        if (i_start) begin
            o_busy <= 1'b1;
            for (n = 0; n < i_pulses; n++) begin
                o_pin <= 1'b1;
                repeat (i_half) @(posedge i_clk);
                o_pin <= 1'b0;
                repeat (i_half) @(posedge i_clk);
            end
            o_busy <= 1'b0;
        end
    end
endmodule

// File: dv/tb_interval_timer.sv
/*
 * self-checking bench for the interval timer: bus tasks and scenarios
 * assumes ext_clock_model on the count clock pin and one 125 MHz clock
 */
`timescale 1ns/10ps
module tb_interval_timer;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0, sleep = 1'b0, osc = 1'b0, st = 1'b0;
    logic [4:0] addr = '0;
    logic [15:0] wdata = '0, rdata, got;
    logic pin, busy, osc_out, irq;
    logic [2:0] prio;
    logic [7:0] np = '0, hf = '0;
    logic [15:0] iv[4] = '{16'h0004, 16'h0020, 16'h0100, 16'h0400};
    logic [15:0] rv[8] = '{16'h0000, 16'h0000, interval_timer_pkg::PERIOD_RESET, 16'h0000, 16'h0000,
        16'h0000, {13'h0000, interval_timer_pkg::PRIO_RESET}, 16'h0000};
    int n_fail = 0, n_tests = 0, cyc = 0, t0;

    // 8 ns clock and a free cycle count for interval checks
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    interval_timer dut_u (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_idle(idle), .i_sleep(sleep), .i_external_count_clock_pin(pin),
        .i_secondary_osc_in(osc), .o_secondary_osc_out(osc_out), .o_irq(irq), .o_counter_irq_priority(prio));
    ext_clock_model src_u (.i_clk(clk), .i_start(st), .i_pulses(np), .i_half(hf), .o_pin(pin), .o_busy(busy));

    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic s);
        chk16(what, {15'h0000, e}, {15'h0000, s});
    endtask
    // one-cycle strobes, changed right after an edge
    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
        chk16(what, e, got);
    endtask
    task automatic rcount(input logic [15:0] e);
        rchk("count", interval_timer_pkg::ADDR_COUNT, e);
    endtask
    // stop, zero the count, clear flags, then start in one control write
    task automatic cfg(input logic [15:0] c);
        wreg(interval_timer_pkg::ADDR_CTRL, 16'h0000);
        wreg(interval_timer_pkg::ADDR_COUNT, 16'h0000);
        wreg(interval_timer_pkg::ADDR_CLEAR, 16'h0003);
        wreg(interval_timer_pkg::ADDR_CTRL, c);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (irq !== 1'b1 && k < 3000);
        chk1("irq raised", 1'b1, irq);
    endtask
    task automatic send(input logic [7:0] p, input logic [7:0] h);
        int k;
        @(posedge clk);
        st <= 1'b1;
        np <= p;
        hf <= h;
        @(posedge clk);
        st <= 1'b0;
        for (k = 0; k < 2000 && (busy !== 1'b0 || k < 2); k++)
            @(posedge clk);
        // room for the pin synchroniser to settle
        repeat (6) @(posedge clk);
        chk1("burst done", 1'b0, busy);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // scenarios
    initial begin
        int k;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 8; k++)
            rchk("reset value", 5'(4 * k), rv[k]);
        wreg(interval_timer_pkg::ADDR_PRIO, 16'h0002);
        rchk("priority", interval_timer_pkg::ADDR_PRIO, 16'h0002);
        chk16("priority pin", 16'h0002, {13'h0000, prio});
        cfg(16'h8000);
        wreg(interval_timer_pkg::ADDR_PERIOD, 16'h0003);
        wreg(interval_timer_pkg::ADDR_ENABLE, 16'h0001);
        wait_irq();
        rcount(16'h0001);
        // match spacing is (period + 1) times the prescale ratio
        for (k = 0; k < 4; k++) begin
            cfg(16'h8000 | 16'(k << 4));
            wait_irq();
            wreg(interval_timer_pkg::ADDR_CLEAR, 16'h0001);
            wait_irq();
            t0 = cyc;
            wreg(interval_timer_pkg::ADDR_CLEAR, 16'h0001);
            wait_irq();
            chk16("match interval", iv[k], 16'(cyc - t0));
        end
        wreg(interval_timer_pkg::ADDR_ENABLE, 16'h0000);
        rchk("status", interval_timer_pkg::ADDR_STATUS, 16'h0001);
        chk1("masked irq", 1'b0, irq);
        // gated accumulation counts only the cycles the gate is high
        cfg(16'h8040);
        wreg(interval_timer_pkg::ADDR_PERIOD, 16'hffff);
        wreg(interval_timer_pkg::ADDR_ENABLE, 16'h0002);
        repeat (10) @(posedge clk);
        rcount(16'h0000);
        send(8'h01, 8'h14);
        rcount(16'h0014);
        chk1("gate irq", 1'b1, irq);
        rchk("status", interval_timer_pkg::ADDR_STATUS, 16'h0002);
        cfg(16'h8006);
        send(8'h0a, 8'h03);
        rcount(16'h000a);
        @(posedge clk);
        sleep <= 1'b1;
        cfg(16'h8002);
        send(8'h07, 8'h03);
        rcount(16'h0007);
        @(posedge clk);
        sleep <= 1'b0;
        idle <= 1'b1;
        // idle stop set: the count must hold while idle
        cfg(16'ha000);
        rcount(16'h0000);
        // idle stop clear: one step per cycle from the enabling write
        cfg(16'h8000);
        rchk("idle count", interval_timer_pkg::ADDR_COUNT, 16'h0001);
        chk1("idle runs", 1'b1, got != 16'h0000);
        @(posedge clk);
        idle <= 1'b0;
        // oscillator input replaces the pin when enabled
        cfg(16'h8007);
        for (k = 0; k < 6; k++) begin
            osc <= 1'b1;
            repeat (3) @(posedge clk);
            osc <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        rcount(16'h0006);
        chk1("osc out", 1'b1, osc_out);
        cfg(16'h0000);
        wreg(interval_timer_pkg::ADDR_COUNT, 16'h1234);
        repeat (20) @(posedge clk);
        rcount(16'h1234);
        chk1("osc out off", 1'b0, osc_out);
        wrap_up();
    end
endmodule
